// *** hdl/lcds_regs.svh ***
/*
  Constants of the LCD drive reset and mode selection block: reset values, timing figures,
  frame and blink divisions, data pointer steps.
  Assumes inclusion by bare name from the core module only.
*/
`ifndef LCDS_REGS_SVH
`define LCDS_REGS_SVH

// ****************************************
// clocking and time
// ****************************************
`define LCDS_CORE_HZ 20000000
`define LCDS_CLK_PERIOD_NS 50
`define LCDS_SETTLE_NS 1000000
`define LCDS_FCLK_HZ 1800

// ****************************************
// frame and blink divisions, in device clock ticks
// ****************************************
`define LCDS_FRAME_TICKS 24
`define LCDS_SLOT_STATIC 4'hc
`define LCDS_SLOT_MUX2 4'h6
`define LCDS_SLOT_MUX3 4'h4
`define LCDS_SLOT_MUX4 4'h3
`define LCDS_BLINK_DIV1 12'h300
`define LCDS_BLINK_DIV2 12'h600
`define LCDS_BLINK_DIV3 12'hc00

// ****************************************
// data pointer steps per drive mode
// ****************************************
`define LCDS_STEP_STATIC 8'h08
`define LCDS_STEP_MUX2 8'h04
`define LCDS_STEP_MUX3 8'h03
`define LCDS_STEP_MUX4 8'h02

// ****************************************
// reset values
// ****************************************
`define LCDS_RST_MODE 2'h0
`define LCDS_RST_HALF_BIAS 1'b0
`define LCDS_RST_ENABLE 1'b0
`define LCDS_RST_BLINK 2'h0
`define LCDS_RST_ALT_BANK 1'b0
`define LCDS_RST_BANK 1'b0
`define LCDS_RST_PTR 8'h00
`define LCDS_RST_SUBADDR 2'h0

`endif

// *** hdl/lcds_pkg.sv ***
/*
  Types of the LCD drive reset and mode selection block: drive modes, output levels,
  sequencer states and the command bundle from the serial command decoder.
  Assumes the decoder delivers each command as a one-cycle strobe with its fields.
*/
package lcds_pkg;

  // ****************************************
  // drive configuration and levels
  // ****************************************
  typedef enum logic [1:0] {
    DM_MUX4 = 2'h0,
    DM_STATIC = 2'h1,
    DM_MUX2 = 2'h2,
    DM_MUX3 = 2'h3
  } lcds_mode_t;

  // level 1 and 2 are the divider taps; they merge when the middle element is bypassed
  typedef enum logic [1:0] {
    LV_VSS = 2'h0,
    LV_LOW = 2'h1,
    LV_HIGH = 2'h2,
    LV_LCD = 2'h3
  } lcds_level_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'h0,
    ST_OFF = 2'h1,
    ST_ON = 2'h3
  } lcds_state_t;

  // ****************************************
  // decoded commands
  // ****************************************
  typedef struct packed {
    logic mode_stb;
    lcds_mode_t mode;
    logic half_bias;
    logic enable;
    logic blink_stb;
    logic alt_bank;
    logic [1:0] blink_freq;
    logic bank_stb;
    logic in_bank;
    logic out_bank;
    logic ptr_stb;
    logic [7:0] ptr;
    logic dev_stb;
    logic [1:0] subaddr;
    logic data_stb;
    logic [7:0] data;
  } lcds_cmd_t;

endpackage : lcds_pkg

// *** hdl/lcds_core.sv ***
/*
  LCD drive core: power-on defaults, drive mode and bias selection, display RAM writes,
  display register, backplane/segment level sequencing, blink and cascade clock pin.
  Assumes a command decoder on core_clk_in delivering lcds_cmd_t strobes, and analog
  switches outside that turn each level code into a voltage.
*/
`timescale 1ns/1ps
`include "lcds_regs.svh"

module lcds_core #(
  parameter int NUM_SEG = 160,
  parameter int SETTLE_CYCLES = (`LCDS_SETTLE_NS + `LCDS_CLK_PERIOD_NS - 1) / `LCDS_CLK_PERIOD_NS,
  parameter int CLK_TICK_CYCLES = `LCDS_CORE_HZ / `LCDS_FCLK_HZ
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic osc_sel_in,
  input wire logic clk_pin_in,
  input wire logic [1:0] hw_subaddr_in,
  input wire lcds_pkg::lcds_cmd_t cmd_in,
  output logic clk_pin_out,
  output logic clk_pin_oe_out,
  output logic ready_out,
  output logic display_enable_out,
  output logic bias_bypass_out,
  output logic frame_start_out,
  output logic [7:0] data_ptr_out,
  output logic [1:0] subaddr_cnt_out,
  output lcds_pkg::lcds_level_t [3:0] bp_level_out,
  output lcds_pkg::lcds_level_t [NUM_SEG-1:0] seg_level_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    lcds_pkg::lcds_state_t st;
    logic [31:0] settle_cnt;
    logic osc_s1;
    logic osc_s2;
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic [1:0] sub_s1;
    logic [1:0] sub_s2;
    logic ext_clk;
    logic [31:0] div_cnt;
    lcds_pkg::lcds_mode_t mode;
    logic half_bias;
    logic enable;
    logic alt_bank;
    logic [1:0] blink_freq;
    logic [11:0] blink_cnt;
    logic in_bank;
    logic out_bank;
    logic [7:0] ptr;
    logic [1:0] subaddr;
    logic [3:0] slot_cnt;
    logic [2:0] slot_idx;
    logic [NUM_SEG-1:0][3:0] ram;
    logic [NUM_SEG-1:0][3:0] disp;
    logic clk_pin;
    logic clk_oe;
    logic ready;
    logic bypass;
    logic frame_start;
    lcds_pkg::lcds_level_t [3:0] bp_lvl;
    lcds_pkg::lcds_level_t [NUM_SEG-1:0] seg_lvl;
  } lcds_core_state_t;

  lcds_core_state_t s;
  lcds_core_state_t next_s;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [3:0] slot_len(input lcds_pkg::lcds_mode_t m);
    case (m)
      lcds_pkg::DM_STATIC: slot_len = `LCDS_SLOT_STATIC;
      lcds_pkg::DM_MUX2: slot_len = `LCDS_SLOT_MUX2;
      lcds_pkg::DM_MUX3: slot_len = `LCDS_SLOT_MUX3;
      default: slot_len = `LCDS_SLOT_MUX4;
    endcase
  endfunction : slot_len

  function automatic logic [2:0] bp_count(input lcds_pkg::lcds_mode_t m);
    case (m)
      lcds_pkg::DM_STATIC: bp_count = 3'h1;
      lcds_pkg::DM_MUX2: bp_count = 3'h2;
      lcds_pkg::DM_MUX3: bp_count = 3'h3;
      default: bp_count = 3'h4;
    endcase
  endfunction : bp_count

  function automatic logic [7:0] ptr_step(input lcds_pkg::lcds_mode_t m);
    case (m)
      lcds_pkg::DM_STATIC: ptr_step = `LCDS_STEP_STATIC;
      lcds_pkg::DM_MUX2: ptr_step = `LCDS_STEP_MUX2;
      lcds_pkg::DM_MUX3: ptr_step = `LCDS_STEP_MUX3;
      default: ptr_step = `LCDS_STEP_MUX4;
    endcase
  endfunction : ptr_step

  // backplane level: the selected plane swings full scale, the others sit on a tap
  function automatic lcds_pkg::lcds_level_t bp_level(input logic sel, input logic pol,
                                                     input logic stat, input logic half);
    if (sel || stat) begin
      bp_level = pol ? lcds_pkg::LV_VSS : lcds_pkg::LV_LCD;
    end else if (half) begin
      bp_level = lcds_pkg::LV_LOW;
    end else begin
      bp_level = pol ? lcds_pkg::LV_LOW : lcds_pkg::LV_HIGH;
    end
  endfunction : bp_level

  function automatic lcds_pkg::lcds_level_t seg_level(input logic on, input logic pol,
                                                      input logic stat, input logic half);
    if (on) begin
      seg_level = pol ? lcds_pkg::LV_LCD : lcds_pkg::LV_VSS;
    end else if (stat || half) begin
      seg_level = pol ? lcds_pkg::LV_VSS : lcds_pkg::LV_LCD;
    end else begin
      seg_level = pol ? lcds_pkg::LV_HIGH : lcds_pkg::LV_LOW;
    end
  endfunction : seg_level

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic tick;
    logic accept;
    logic restart;
    logic stat;
    logic pol;
    logic blank;
    logic [2:0] nbp;
    logic [2:0] bp;
    logic [1:0] row_base;
    logic [1:0] row;
    logic [11:0] bdiv;
    logic [8:0] col;
    logic [8:0] ptr_sum;
    int k;
    tick = 1'b0;
    accept = 1'b0;
    restart = 1'b0;
    stat = 1'b0;
    pol = 1'b0;
    blank = 1'b0;
    nbp = 3'h0;
    bp = 3'h0;
    row_base = 2'h0;
    row = 2'h0;
    bdiv = 12'h000;
    col = 9'h000;
    ptr_sum = 9'h000;
    k = 1;
    next_s = s;

    // pins pass two flops before use
    next_s.osc_s1 = osc_sel_in;
    next_s.osc_s2 = s.osc_s1;
    next_s.clk_s1 = clk_pin_in;
    next_s.clk_s2 = s.clk_s1;
    next_s.clk_s3 = s.clk_s2;
    next_s.sub_s1 = hw_subaddr_in;
    next_s.sub_s2 = s.sub_s1;

    // device clock tick: internal divider or rising edge on the clock pin
    if (s.div_cnt >= 32'(CLK_TICK_CYCLES - 1)) begin
      next_s.div_cnt = 32'h0000_0000;
    end else begin
      next_s.div_cnt = s.div_cnt + 32'h0000_0001;
    end
    if (s.ext_clk) begin
      tick = s.clk_s2 && !s.clk_s3;
    end else begin
      tick = (s.div_cnt == 32'(CLK_TICK_CYCLES - 1));
    end

    // sequencer; commands are taken only once the settling interval has run
    case (s.st)
      lcds_pkg::ST_SETTLE: begin
        next_s.settle_cnt = s.settle_cnt + 32'h0000_0001;
        if (s.settle_cnt >= 32'(SETTLE_CYCLES - 1)) begin
          next_s.ext_clk = s.osc_s2;
          next_s.ready = 1'b1;
          next_s.st = lcds_pkg::ST_OFF;
        end
      end
      lcds_pkg::ST_OFF: begin
        accept = 1'b1;
        if (s.enable) begin
          next_s.st = lcds_pkg::ST_ON;
        end
      end
      lcds_pkg::ST_ON: begin
        accept = 1'b1;
        if (!s.enable) begin
          next_s.st = lcds_pkg::ST_OFF;
        end
      end
      default: begin
        next_s.st = lcds_pkg::ST_SETTLE;
      end
    endcase

    // ****************************************
    // commands
    // ****************************************
    if (accept && cmd_in.mode_stb) begin
      next_s.mode = cmd_in.mode;
      next_s.half_bias = cmd_in.half_bias && (cmd_in.mode != lcds_pkg::DM_STATIC);
      next_s.enable = cmd_in.enable;
      // restart the frame so the slot index never reaches twice the new plane count
      next_s.slot_cnt = 4'h0;
      next_s.slot_idx = 3'h0;
    end
    if (accept && cmd_in.blink_stb) begin
      next_s.blink_freq = cmd_in.blink_freq;
      next_s.alt_bank = cmd_in.alt_bank;
    end
    // bank selectors have no effect with three or four planes
    if (accept && cmd_in.bank_stb && (s.mode == lcds_pkg::DM_STATIC || s.mode == lcds_pkg::DM_MUX2)) begin
      next_s.in_bank = cmd_in.in_bank;
      next_s.out_bank = cmd_in.out_bank;
    end
    if (accept && cmd_in.dev_stb) begin
      next_s.subaddr = cmd_in.subaddr;
    end
    if (accept && cmd_in.ptr_stb) begin
      next_s.ptr = cmd_in.ptr;
    end else if (accept && cmd_in.data_stb) begin
      k = int'(bp_count(s.mode));
      row_base = (s.in_bank && (s.mode == lcds_pkg::DM_STATIC || s.mode == lcds_pkg::DM_MUX2)) ? 2'h2 : 2'h0;
      // storage only on subaddress match; the pointer advances either way
      if (s.subaddr == s.sub_s2) begin
        for (int i = 0; i < 8; i++) begin
          col = 9'({1'b0, s.ptr} + 9'(i / k));
          row = 2'(row_base + 2'(i % k));
          if (col < 9'(NUM_SEG)) begin
            next_s.ram[col[7:0]][row] = cmd_in.data[7 - i];
          end
        end
      end
      ptr_sum = {1'b0, s.ptr} + {1'b0, ptr_step(s.mode)};
      if (ptr_sum >= 9'(NUM_SEG)) begin
        next_s.ptr = 8'(ptr_sum - 9'(NUM_SEG));
        next_s.subaddr = s.subaddr + 2'h1;
      end else begin
        next_s.ptr = ptr_sum[7:0];
      end
    end

    // ****************************************
    // frame timing: 2n slots of 24/2n ticks, second half inverted
    // ****************************************
    nbp = bp_count(s.mode);
    next_s.frame_start = 1'b0;
    // a mode command on a tick keeps its restart; stepping on would leave a stale slot index
    restart = accept && cmd_in.mode_stb;
    if (s.st == lcds_pkg::ST_ON && tick && !restart) begin
      if (s.slot_cnt == slot_len(s.mode) - 4'h1) begin
        next_s.slot_cnt = 4'h0;
        if (s.slot_idx == 3'((nbp << 1) - 3'h1)) begin
          next_s.slot_idx = 3'h0;
        end else begin
          next_s.slot_idx = s.slot_idx + 3'h1;
        end
      end else begin
        next_s.slot_cnt = s.slot_cnt + 4'h1;
      end
    end
    // display register reloads only at the frame boundary
    if (s.st == lcds_pkg::ST_ON && tick && !restart && s.slot_cnt == 4'h0 && s.slot_idx == 3'h0) begin
      next_s.disp = s.ram;
      next_s.frame_start = 1'b1;
    end

    // ****************************************
    // blink
    // ****************************************
    case (s.blink_freq)
      2'h1: bdiv = `LCDS_BLINK_DIV1;
      2'h2: bdiv = `LCDS_BLINK_DIV2;
      2'h3: bdiv = `LCDS_BLINK_DIV3;
      default: bdiv = 12'h000;
    endcase
    if (s.blink_freq == 2'h0) begin
      next_s.blink_cnt = 12'h000;
    end else if (tick) begin
      next_s.blink_cnt = (s.blink_cnt >= bdiv - 12'h001) ? 12'h000 : s.blink_cnt + 12'h001;
    end
    blank = (s.blink_freq != 2'h0) && (s.blink_cnt >= (bdiv >> 1));

    // ****************************************
    // output levels, taken from the display register
    // ****************************************
    stat = (s.mode == lcds_pkg::DM_STATIC);
    pol = (s.slot_idx >= nbp);
    bp = pol ? 3'(s.slot_idx - nbp) : s.slot_idx;
    row_base = 2'h0;
    if (stat || s.mode == lcds_pkg::DM_MUX2) begin
      // alternate bank blinking swaps banks instead of blanking
      row_base = (s.out_bank ^ (blank && s.alt_bank)) ? 2'h2 : 2'h0;
    end
    row = 2'(row_base + bp[1:0]);
    next_s.bypass = s.half_bias;
    if (s.st == lcds_pkg::ST_ON) begin
      for (int b = 0; b < 4; b++) begin
        // plane count is never zero, so the modulo is safe; with four planes it is the identity
        next_s.bp_lvl[b] = bp_level(b % int'(nbp) == int'(bp), pol, stat, s.half_bias);
      end
      for (int g = 0; g < NUM_SEG; g++) begin
        next_s.seg_lvl[g] = seg_level(s.disp[g][row] && !(blank && !s.alt_bank),
                                      pol, stat, s.half_bias);
      end
    end else begin
      for (int b = 0; b < 4; b++) begin
        next_s.bp_lvl[b] = lcds_pkg::LV_LCD;
      end
      for (int g = 0; g < NUM_SEG; g++) begin
        next_s.seg_lvl[g] = lcds_pkg::LV_LCD;
      end
    end

    // cascade clock pin: driven only with internal source, toggles only when enabled
    next_s.clk_oe = (s.st != lcds_pkg::ST_SETTLE) && !s.ext_clk;
    next_s.clk_pin = next_s.clk_oe && s.enable && (s.div_cnt >= 32'(CLK_TICK_CYCLES / 2));
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
      s.st <= lcds_pkg::ST_SETTLE;
      s.mode <= lcds_pkg::lcds_mode_t'(`LCDS_RST_MODE);
      s.half_bias <= `LCDS_RST_HALF_BIAS;
      s.enable <= `LCDS_RST_ENABLE;
      s.blink_freq <= `LCDS_RST_BLINK;
      s.alt_bank <= `LCDS_RST_ALT_BANK;
      s.in_bank <= `LCDS_RST_BANK;
      s.out_bank <= `LCDS_RST_BANK;
      s.ptr <= `LCDS_RST_PTR;
      s.subaddr <= `LCDS_RST_SUBADDR;
      s.clk_pin <= 1'b0;
      s.clk_oe <= 1'b0;
      s.bp_lvl <= {4{lcds_pkg::LV_LCD}};
      s.seg_lvl <= {NUM_SEG{lcds_pkg::LV_LCD}};
    end else begin
      s <= next_s;
    end
  end

  assign clk_pin_out = s.clk_pin;
  assign clk_pin_oe_out = s.clk_oe;
  assign ready_out = s.ready;
  assign display_enable_out = s.enable;
  assign bias_bypass_out = s.bypass;
  assign frame_start_out = s.frame_start;
  assign data_ptr_out = s.ptr;
  assign subaddr_cnt_out = s.subaddr;
  assign bp_level_out = s.bp_lvl;
  assign seg_level_out = s.seg_lvl;

endmodule : lcds_core

// *** dv/lcds_core_sva.sv ***
/*
  Checker of the LCD drive core, watching only its ports.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module lcds_core_sva #(
  parameter int NUM_SEG = 160,
  parameter int SETTLE_CYCLES = 20000,
  parameter int CLK_TICK_CYCLES = 11111
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic osc_sel_in,
  input wire logic clk_pin_in,
  input wire logic [1:0] hw_subaddr_in,
  input wire lcds_pkg::lcds_cmd_t cmd_in,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe_out,
  input wire logic ready_out,
  input wire logic display_enable_out,
  input wire logic bias_bypass_out,
  input wire logic frame_start_out,
  input wire logic [7:0] data_ptr_out,
  input wire logic [1:0] subaddr_cnt_out,
  input wire lcds_pkg::lcds_level_t [3:0] bp_level_out,
  input wire lcds_pkg::lcds_level_t [NUM_SEG-1:0] seg_level_out
);
  localparam int FRAME_CYC = 24 * CLK_TICK_CYCLES;
  logic [15:0] since_rst;
  logic [31:0] quiet;
  logic [31:0] gap;
  logic want_bypass;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  assign want_bypass = cmd_in.half_bias && cmd_in.mode != lcds_pkg::DM_STATIC;
  // quiet counts cycles of undisturbed internal frames; a mode command restarts the frame
  // gap counts cycles since the last frame start
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      since_rst <= 16'h0000;
      quiet <= 32'h0000_0000;
      gap <= 32'h0000_0000;
    end else begin
      if (since_rst != 16'hffff) since_rst <= since_rst + 16'h0001;
      if (cmd_in.mode_stb || osc_sel_in || !display_enable_out) quiet <= 32'h0000_0000;
      else if (quiet != 32'hffff_ffff) quiet <= quiet + 32'h0000_0001;
      if (frame_start_out) gap <= 32'h0000_0000;
      else if (gap != 32'hffff_ffff) gap <= gap + 32'h0000_0001;
    end
  end
  ready_timing_a: assert property (ready_out == (since_rst >= SETTLE_CYCLES))
    else $error("ready_out not at settle count");
  reset_values_a: assert property ($rose(rst_b_in) |-> data_ptr_out == 8'h00 && subaddr_cnt_out == 2'h0
    && !display_enable_out && !bias_bypass_out) else $error("reset values wrong");
  idle_levels_a: assert property (!display_enable_out[*3] |-> &bp_level_out && &seg_level_out)
    else $error("disabled outputs not at lcd supply level");
  no_cascade_clk_a: assert property (!display_enable_out[*3] |-> !clk_pin_out)
    else $error("clock pin toggles while disabled");
  ext_no_drive_a: assert property (osc_sel_in[*4] |-> !clk_pin_oe_out)
    else $error("clock pin driven with external source");
  int_drive_a: assert property ((ready_out && !osc_sel_in)[*4] |-> clk_pin_oe_out)
    else $error("clock pin not driven with internal source");
  enable_follow_a: assert property (ready_out && cmd_in.mode_stb |=> display_enable_out == $past(cmd_in.enable))
    else $error("display enable does not follow command");
  bypass_select_a: assert property (ready_out && cmd_in.mode_stb |=> ##1 bias_bypass_out == $past(want_bypass, 2))
    else $error("bias bypass switch wrong");
  ptr_load_a: assert property (ready_out && cmd_in.ptr_stb |=> data_ptr_out == $past(cmd_in.ptr))
    else $error("data pointer load wrong");
  early_cmd_a: assert property (!ready_out && (cmd_in.ptr_stb || cmd_in.dev_stb)
    |=> $stable(data_ptr_out) && $stable(subaddr_cnt_out)) else $error("command taken before settle");
  frame_period_a: assert property (frame_start_out && quiet > 32'(FRAME_CYC) |-> gap == 32'(FRAME_CYC - 1))
    else $error("frame period not 24 ticks");
endmodule : lcds_core_sva

bind lcds_core lcds_core_sva #(.NUM_SEG(NUM_SEG), .SETTLE_CYCLES(SETTLE_CYCLES), .CLK_TICK_CYCLES(CLK_TICK_CYCLES))
  i_sva (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .osc_sel_in(osc_sel_in), .clk_pin_in(clk_pin_in),
  .hw_subaddr_in(hw_subaddr_in), .cmd_in(cmd_in), .clk_pin_out(clk_pin_out), .clk_pin_oe_out(clk_pin_oe_out),
  .ready_out(ready_out), .display_enable_out(display_enable_out), .bias_bypass_out(bias_bypass_out),
  .frame_start_out(frame_start_out), .data_ptr_out(data_ptr_out), .subaddr_cnt_out(subaddr_cnt_out),
  .bp_level_out(bp_level_out), .seg_level_out(seg_level_out));

// *** dv/lcds_host.sv ***
/*
  Host model: hands decoded commands to the core as one-cycle strobes.
  Assumes the core clock and a testbench that calls send.
*/
`timescale 1ns/1ps
module lcds_host (
  input wire logic core_clk_in,
  input wire logic ready_in,
  output lcds_pkg::lcds_cmd_t cmd_out
);
  initial cmd_out = '0;
  // early is set only by a scenario that wants a command refused
  task automatic send(input lcds_pkg::lcds_cmd_t c, input logic early);
    int n;
    n = 0;
    while (!early && ready_in !== 1'b1 && n < 1000) begin
      @(negedge core_clk_in);
      n++;
    end
    @(negedge core_clk_in);
    cmd_out = c;
    @(negedge core_clk_in);
    cmd_out = '0;
  endtask : send
endmodule : lcds_host

// *** dv/testbench.sv ***
/*
  Testbench of the LCD drive core with the host model; one task per scenario.
  Assumes short settle, tick and segment counts chosen below.
*/
`timescale 1ns/1ps
module testbench;
  localparam int NSEG = 16;
  localparam int TICK = 4;
  logic core_clk_in, rst_b_in, osc_sel_in, clk_pin_in, ext_clk;
  logic clk_pin_out, clk_pin_oe_out, ready_out, display_enable_out, bias_bypass_out, frame_start_out;
  logic [1:0] hw_subaddr_in;
  logic [1:0] subaddr_cnt_out;
  logic [7:0] data_ptr_out;
  lcds_pkg::lcds_cmd_t cmd;
  lcds_pkg::lcds_level_t [3:0] bp;
  lcds_pkg::lcds_level_t [NSEG-1:0] seg;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  // the clock pin wire: the core's driver wins while enabled
  assign clk_pin_in = clk_pin_oe_out ? clk_pin_out : ext_clk;
  lcds_core #(.NUM_SEG(NSEG), .SETTLE_CYCLES(16), .CLK_TICK_CYCLES(TICK)) i_dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .osc_sel_in(osc_sel_in), .clk_pin_in(clk_pin_in),
    .hw_subaddr_in(hw_subaddr_in), .cmd_in(cmd), .clk_pin_out(clk_pin_out), .clk_pin_oe_out(clk_pin_oe_out),
    .ready_out(ready_out), .display_enable_out(display_enable_out), .bias_bypass_out(bias_bypass_out),
    .frame_start_out(frame_start_out), .data_ptr_out(data_ptr_out), .subaddr_cnt_out(subaddr_cnt_out),
    .bp_level_out(bp), .seg_level_out(seg));
  lcds_host i_host (.core_clk_in(core_clk_in), .ready_in(ready_out), .cmd_out(cmd));
  // ****
  // common tasks
  // ****
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // kind 0 mode {enable, half, mode}, 1 pointer load, 2 data byte, 3 blink {alt, freq}
  function automatic lcds_pkg::lcds_cmd_t mk(input logic [1:0] kind, input logic [7:0] v);
    lcds_pkg::lcds_cmd_t c;
    c = '0;
    c.mode = lcds_pkg::lcds_mode_t'(v[1:0]);
    c.half_bias = v[2];
    c.enable = v[3];
    c.ptr = v;
    c.data = v;
    c.blink_freq = v[1:0];
    c.alt_bank = v[2];
    c.blink_stb = (kind == 2'h3);
    c.mode_stb = (kind == 2'h0);
    c.ptr_stb = (kind == 2'h1);
    c.data_stb = (kind == 2'h2);
    return c;
  endfunction : mk
  function automatic logic [1:0] exp_bp(input int n, input int s, input int i, input logic half);
    logic pol;
    pol = (s >= n);
    if (i % n == s % n) return pol ? 2'h0 : 2'h3;
    if (half) return 2'h1;
    return pol ? 2'h1 : 2'h2;
  endfunction : exp_bp
  task automatic wait_frame;
    int n;
    n = 0;
    while (frame_start_out !== 1'b1 && n < 400) begin
      @(negedge core_clk_in);
      n++;
    end
    cmp("frame start", 8'h01, {7'h0, frame_start_out});
  endtask : wait_frame
  // the strap is taken only as settling ends, so it changes under reset
  task automatic restart_with_strap(input logic strap);
    rst_b_in = 1'b0;
    osc_sel_in = strap;
    repeat (3) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    while (ready_out !== 1'b1) @(negedge core_clk_in);
  endtask : restart_with_strap
  task automatic chk_defaults;
    cmp("idle flags", 8'hc0, {&bp, &seg, display_enable_out, bias_bypass_out, clk_pin_out, clk_pin_oe_out,
      ready_out, frame_start_out});
    cmp("data pointer", 8'h00, data_ptr_out);
    cmp("subaddress count", 8'h00, {6'h0, subaddr_cnt_out});
  endtask : chk_defaults
  // ****
  // scenarios
  // ****
  task automatic t_reset_defaults;
    int n;
    n = 0;
    @(negedge core_clk_in);
    chk_defaults();
    i_host.send(mk(2'h1, 8'h05), 1'b1);
    cmp("early pointer", 8'h00, data_ptr_out);
    while (ready_out !== 1'b1 && n < 40) begin
      @(negedge core_clk_in);
      n++;
    end
    cmp("ready", 8'h01, {7'h0, ready_out});
  endtask : t_reset_defaults
  task automatic t_modes;
    logic [3:0] cfg [7];
    int n;
    int len;
    cfg = '{4'h8, 4'hc, 4'h9, 4'ha, 4'he, 4'hb, 4'hf};
    foreach (cfg[k]) begin
      n = (cfg[k][1:0] == 2'h0) ? 4 : int'(cfg[k][1:0]);
      len = 12 / n * TICK;
      i_host.send(mk(2'h0, {4'h0, cfg[k]}), 1'b0);
      wait_frame();
      for (int s = 0; s < 2; s++) begin
        repeat (len / 2 + s * len / 2) @(negedge core_clk_in);
        // backplane 3 in three-backplane mode is left unchecked
        for (int i = 0; i < 4; i++) begin
          if (!(n == 3 && i == 3)) cmp("backplane", {6'h0, exp_bp(n, s, i, cfg[k][2])}, {6'h0, bp[i]});
        end
      end
      cmp("bias bypass", {7'h0, cfg[k][2] && n != 1}, {7'h0, bias_bypass_out});
    end
  endtask : t_modes
  task automatic t_data;
    i_host.send(mk(2'h0, 8'h08), 1'b0);
    i_host.send(mk(2'h1, 8'h00), 1'b0);
    i_host.send(mk(2'h2, 8'hff), 1'b0);
    i_host.send(mk(2'h2, 8'h00), 1'b0);
    cmp("data pointer", 8'h04, data_ptr_out);
    wait_frame();
    repeat (6) @(negedge core_clk_in);
    cmp("segment on", 8'h00, {6'h0, seg[0]});
    cmp("segment off", 8'h01, {6'h0, seg[2]});
    // normal blinking: about 425 ticks in, the lit column shows the off levels
    i_host.send(mk(2'h3, 8'h01), 1'b0);
    repeat (1700) @(negedge core_clk_in);
    cmp("blink blanked", 8'h01, {7'h0, ^seg[0]});
    i_host.send(mk(2'h3, 8'h00), 1'b0);
    @(negedge core_clk_in);
    cmp("blink off", 8'h00, {7'h0, ^seg[0]});
    i_host.send(mk(2'h1, 8'h0e), 1'b0);
    i_host.send(mk(2'h2, 8'h00), 1'b0);
    cmp("wrapped pointer", 8'h00, data_ptr_out);
    cmp("subaddress count", 8'h01, {6'h0, subaddr_cnt_out});
  endtask : t_data
  task automatic t_clock;
    int hits;
    hits = 0;
    repeat (40) begin
      @(negedge core_clk_in);
      hits += clk_pin_out;
    end
    cmp("cascade clock", 8'h01, {7'h0, hits > 0 && clk_pin_oe_out});
    i_host.send(mk(2'h0, 8'h00), 1'b0);
    hits = 0;
    repeat (8) begin
      @(negedge core_clk_in);
      hits += clk_pin_out;
    end
    cmp("clock stopped", 8'h00, 8'(hits));
    restart_with_strap(1'b1);
    repeat (4) @(negedge core_clk_in);
    cmp("pin released", 8'h00, {7'h0, clk_pin_oe_out});
    i_host.send(mk(2'h0, 8'h08), 1'b0);
    hits = 0;
    for (int k = 0; k < 480; k++) begin
      @(negedge core_clk_in);
      if (k % 2 == 0) ext_clk = ~ext_clk;
      hits += frame_start_out;
    end
    cmp("external frames", 8'h01, {7'h0, hits >= 4 && hits <= 5});
    restart_with_strap(1'b0);
  endtask : t_clock
  task automatic t_midreset;
    i_host.send(mk(2'h0, 8'h08), 1'b0);
    i_host.send(mk(2'h1, 8'h07), 1'b0);
    rst_b_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    @(negedge core_clk_in);
    chk_defaults();
  endtask : t_midreset
  // ****
  // clock, watchdog and main sequence
  // ****
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    rst_b_in = 1'b0;
    osc_sel_in = 1'b0;
    ext_clk = 1'b0;
    hw_subaddr_in = 2'h0;
    repeat (12) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    t_reset_defaults();
    t_modes();
    t_data();
    t_clock();
    t_midreset();
    report_and_stop();
  end
endmodule : testbench
